// *** atic_core_model.sv ***
// atic_core_model: integer unit side, takes and acks trap requests
// assumes: same clk_i and rst_i as atic_ctrl
`timescale 1ns/100ps
module atic_core_model
  import atic_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_req_i,
  input  wire logic [7:0] irq_type_i,
  input  wire logic       ack_en_i,
  input  wire logic [3:0] ack_dly_i,
  output logic            irq_ack_o,
  output logic            taken_o,
  output logic [7:0]      taken_type_o
);
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic       ack_d;
  logic       taken_d;
  logic [7:0] type_d;
  // ==========================================
  // ack pulse ack_dly_i+1 cycles after request rises
  always_comb begin
    wait_d  = (irq_req_i && !irq_ack_o) ? wait_q + 4'h1 : 4'h0;
    ack_d   = irq_req_i && !irq_ack_o && ack_en_i && wait_q >= ack_dly_i;
    taken_d = irq_ack_o && irq_req_i;
    type_d  = taken_d ? irq_type_i : taken_type_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q       <= 4'h0;
      irq_ack_o    <= 1'b0;
      taken_o      <= 1'b0;
      taken_type_o <= 8'h00;
    end else begin
      wait_q       <= wait_d;
      irq_ack_o    <= ack_d;
      taken_o      <= taken_d;
      taken_type_o <= type_d;
    end
  end
endmodule : atic_core_model

// *** atic_ctrl.sv ***
// atic_ctrl: ranks interrupt sources and hands trap types to the core
// assumes: all event inputs except pins are on clk_i; pins are async
`timescale 1ns/100ps
// ==========================================================
// Functional notes
// [RL1] levels 13..27 map to trap types 1Fh down to 11h
// [RL2] watchdog request from internal watchdog or external pin
// [RL3] external acknowledge marks only the line being serviced
// [RL4] level 27 is OR of three masked hardware error inputs
// [RL5] corrected memory error raises type 16h request
// [RL6] every source maskable except watchdog time-out
// [RL7] acknowledge clears the pending bit in hardware
// [RL8] shape setting selects active low or high external inputs
// [RL9] shape setting selects edge or level detection
// [RL10] realtime timer outranks general timer
// [RL11] UART byte events types 15h/14h, UART error type 17h
// [RL12] both timers raise request when delay expires
// [RL13] unreloaded watchdog requests then resets after timeout; an acknowledge of the watchdog request also cancels the reset
// [RL14] board ties internal watchdog enable high to use it
// [RL15] any asserted external input ends power-down
// [RL16] synchronous traps outrank all interrupts
// [RL17] error output on unmasked error, errors latched in status
// [RL18] parallel-port transition gives two-clock positive pulse
// [RL19] lowest pending unmasked level presented until acknowledged
module atic_ctrl
  import atic_pkg::*;
#(
  parameter int WD_RST_CYC = WD_RST_CYC_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [NUM_EXT-1:0]  ext_irq_in_i,
  input  wire logic                ext_watchdog_irq_in_i,
  input  wire logic                internal_wdog_enable_pin_i,
  input  wire logic                wdog_expired_i,
  input  wire logic                wdog_reload_i,
  input  wire logic                realtime_timer_done_i,
  input  wire logic                general_timer_done_i,
  input  wire logic                dma_timeout_i,
  input  wire logic                dma_access_err_i,
  input  wire logic                uart_err_i,
  input  wire logic                ecc_corrected_i,
  input  wire logic                uart_b_event_i,
  input  wire logic                uart_a_event_i,
  input  wire logic                iu_hw_err_i,
  input  wire logic                iu_err_mode_i,
  input  wire logic                sys_hw_err_i,
  input  wire logic                fpu_err_i,
  input  wire logic [2:0]          err_mask_i,
  input  wire logic [NUM_SRC-1:0]  irq_mask_i,
  input  wire logic [NUM_EXT-1:0]  ext_active_high_i,
  input  wire logic [NUM_EXT-1:0]  ext_edge_i,
  input  wire logic                power_down_req_i,
  input  wire logic [PP_WIDTH-1:0] parallel_port_i,
  input  wire logic [PP_WIDTH-1:0] parallel_port_sel_i,
  input  wire logic                sync_trap_i,
  input  wire logic                irq_ack_i,
  output logic                     irq_req_o,
  output logic [7:0]               irq_type_o,
  output logic [NUM_EXT-1:0]       ext_irq_ack_out_o,
  output logic                     power_down_o,
  output logic                     error_out_o,
  output logic [4:0]               err_status_o,
  output logic                     wdog_reset_o,
  output logic                     parport_irq_pulse_o
);

  // ==========================================================
  // elaboration checks
  if (WD_RST_CYC < 1 || WD_RST_CYC > 65535) begin : g_chk
    $error("WD_RST_CYC out of range");
  end

  function automatic logic [7:0] level_type(input logic [3:0] idx);
    level_type = TT_TOP - {4'h0, idx};
  endfunction : level_type

  function automatic int ext_src(input int n);
    case (n)
      0:       ext_src = SRC_EXT0;
      1:       ext_src = SRC_EXT1;
      2:       ext_src = SRC_EXT2;
      3:       ext_src = SRC_EXT3;
      default: ext_src = SRC_EXT4;
    endcase
  endfunction : ext_src

  // ==========================================================
  // pin synchronisers
  logic [NUM_EXT-1:0]  ext_m_q, ext_s_q, ext_p_q;
  logic                ewd_m_q, ewd_s_q, ewd_p_q;
  logic [PP_WIDTH-1:0] pp_m_q, pp_s_q, pp_p_q;
  logic                internal_wdog_enable_pin_m_q, internal_wdog_enable_pin_s_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_m_q  <= '0;
      ext_s_q  <= '0;
      ext_p_q  <= '0;
      ewd_m_q  <= 1'b0;
      ewd_s_q  <= 1'b0;
      ewd_p_q  <= 1'b0;
      pp_m_q   <= '0;
      pp_s_q   <= '0;
      pp_p_q   <= '0;
      internal_wdog_enable_pin_m_q <= 1'b0;
      internal_wdog_enable_pin_s_q <= 1'b0;
    end else begin
      ext_m_q  <= ext_irq_in_i;
      ext_s_q  <= ext_m_q;
      ext_p_q  <= ext_s_q;
      ewd_m_q  <= ext_watchdog_irq_in_i;
      ewd_s_q  <= ewd_m_q;
      ewd_p_q  <= ewd_s_q;
      pp_m_q   <= parallel_port_i;
      pp_s_q   <= pp_m_q;
      pp_p_q   <= pp_s_q;
      internal_wdog_enable_pin_m_q <= internal_wdog_enable_pin_i;
      internal_wdog_enable_pin_s_q <= internal_wdog_enable_pin_m_q;
    end
  end

  // ==========================================================
  // external line shaping
  logic [NUM_EXT-1:0] ext_lvl, ext_prev, ext_evt;
  always_comb begin
    ext_lvl  = ~(ext_s_q ^ ext_active_high_i);   // [RL8]
    ext_prev = ~(ext_p_q ^ ext_active_high_i);
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_evt[i] = ext_edge_i[i] ? (ext_lvl[i] & ~ext_prev[i])
                                 : ext_lvl[i];   // [RL9]
    end
  end

  // ==========================================================
  // watchdog reset timeout
  logic        wd_run_q, wd_run_d;
  logic [15:0] wd_cnt_q, wd_cnt_d;
  logic        wd_rst_q, wd_rst_d;
  logic        wd_int_evt, wd_evt, wd_ack;

  always_comb begin
    wd_int_evt = wdog_expired_i & internal_wdog_enable_pin_s_q;
    wd_evt     = wd_int_evt | (ewd_s_q & ~ewd_p_q);   // [RL2]
    wd_run_d   = wd_run_q;
    wd_cnt_d   = wd_cnt_q;
    wd_rst_d   = 1'b0;
    if (wd_run_q) begin
      if (wd_ack || wdog_reload_i) begin
        wd_run_d = 1'b0;
      end else if (wd_cnt_q == 16'h0000) begin
        wd_rst_d = 1'b1;                              // [RL13]
        wd_run_d = 1'b0;
      end else begin
        wd_cnt_d = wd_cnt_q - 16'h0001;
      end
    end else if (wd_int_evt) begin
      wd_run_d = 1'b1;                                // [RL13]
      wd_cnt_d = 16'(WD_RST_CYC - 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_run_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_rst_q <= 1'b0;
    end else begin
      wd_run_q <= wd_run_d;
      wd_cnt_q <= wd_cnt_d;
      wd_rst_q <= wd_rst_d;
    end
  end

  // ==========================================================
  // pending, priority and acknowledge
  logic [NUM_SRC-1:0] pend_q, pend_d, set_v, eff_mask, live;
  logic               req_q, req_d;
  logic [7:0]         type_q, type_d;
  logic [3:0]         idx_q, idx_d, win;
  logic               found;
  logic [NUM_EXT-1:0] xack_q, xack_d;
  logic               hw_err;

  assign wd_ack = irq_ack_i & req_q & (idx_q == 4'(SRC_WDOG));

  always_comb begin
    hw_err = |({iu_hw_err_i, iu_err_mode_i, sys_hw_err_i}
               & err_mask_i);                       // [RL4]
    set_v  = '0;
    set_v[SRC_WDOG]    = wd_evt;
    set_v[SRC_RTT]     = realtime_timer_done_i;     // [RL12]
    set_v[SRC_GPT]     = general_timer_done_i;      // [RL12]
    set_v[SRC_DMA_TO]  = dma_timeout_i;
    set_v[SRC_DMA_ERR] = dma_access_err_i;
    set_v[SRC_UERR]    = uart_err_i;                // [RL11]
    set_v[SRC_ECC]     = ecc_corrected_i;           // [RL5]
    set_v[SRC_UARTB]   = uart_b_event_i;            // [RL11]
    set_v[SRC_UARTA]   = uart_a_event_i;            // [RL11]
    set_v[SRC_HWERR]   = hw_err;
    for (int i = 0; i < NUM_EXT; i++) begin
      set_v[ext_src(i)] = ext_evt[i];
    end
    eff_mask = irq_mask_i;
    eff_mask[SRC_WDOG] = 1'b1;                      // [RL6]

    pend_d = pend_q;
    xack_d = '0;
    if (irq_ack_i && req_q) begin
      pend_d[idx_q] = 1'b0;                         // [RL7]
      for (int i = 0; i < NUM_EXT; i++) begin
        xack_d[i] = (idx_q == 4'(ext_src(i)));      // [RL3]
      end
    end
    pend_d = pend_d | set_v;                        // set wins

    live  = pend_q & eff_mask;
    found = 1'b0;
    win   = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        found = 1'b1;
        win   = 4'(i);                              // [RL19] [RL10]
      end
    end
    if (irq_ack_i && req_q) begin
      req_d = 1'b0;
      idx_d = idx_q;
    end else begin
      req_d = found & ~sync_trap_i;                 // [RL16]
      idx_d = win;
    end
    type_d = level_type(idx_d);                     // [RL1]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= PEND_RST;
      req_q  <= 1'b0;
      idx_q  <= '0;
      type_q <= TT_TOP;
      xack_q <= '0;
    end else begin
      pend_q <= pend_d;
      req_q  <= req_d;
      idx_q  <= idx_d;
      type_q <= type_d;
      xack_q <= xack_d;
    end
  end

  // ==========================================================
  // power-down, errors, parallel-port pulse
  logic       pd_q, pd_d;
  logic [4:0] est_q, est_d;
  logic       err_q, err_d;
  logic [1:0] pp_cnt_q, pp_cnt_d;
  logic       ppp_q, ppp_d;
  logic       pp_evt;

  always_comb begin
    pd_d = pd_q;
    if (|ext_lvl) begin
      pd_d = 1'b0;                                  // [RL15]
    end else if (power_down_req_i) begin
      pd_d = 1'b1;
    end
    est_d = est_q | {fpu_err_i, sys_hw_err_i, iu_err_mode_i,
                     iu_hw_err_i, wd_rst_q};        // [RL17]
    err_d = hw_err;                                 // [RL17]
    pp_evt   = |((pp_s_q ^ pp_p_q) & parallel_port_sel_i);
    pp_cnt_d = pp_cnt_q;
    if (pp_evt) begin
      pp_cnt_d = 2'(PP_PULSE_CYC);                  // [RL18]
    end else if (pp_cnt_q != 2'h0) begin
      pp_cnt_d = pp_cnt_q - 2'h1;
    end
    ppp_d = (pp_cnt_d != 2'h0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_q     <= 1'b0;
      est_q    <= '0;
      err_q    <= 1'b0;
      pp_cnt_q <= '0;
      ppp_q    <= 1'b0;
    end else begin
      pd_q     <= pd_d;
      est_q    <= est_d;
      err_q    <= err_d;
      pp_cnt_q <= pp_cnt_d;
      ppp_q    <= ppp_d;
    end
  end

  assign irq_req_o           = req_q;
  assign irq_type_o          = type_q;
  assign ext_irq_ack_out_o   = xack_q;
  assign power_down_o        = pd_q;
  assign error_out_o         = err_q;
  assign err_status_o        = est_q;
  assign wdog_reset_o        = wd_rst_q;
  assign parport_irq_pulse_o = ppp_q;

  // ==========================================================
  // assertions
  property p_type_range;
    @(posedge clk_i) disable iff (rst_i)
      irq_req_o |-> (irq_type_o <= TT_TOP && irq_type_o >= TT_BOTTOM);
  endproperty
  a_type_range: assert property (p_type_range) // [RL1]
    else $error("trap type out of range");

  property p_wd_first;
    @(posedge clk_i) disable iff (rst_i)
      pend_q[SRC_WDOG] && !sync_trap_i && !(irq_ack_i && req_q)
        |=> irq_req_o && irq_type_o == TT_TOP;
  endproperty
  a_wd_first: assert property (p_wd_first) // [RL2]
    else $error("watchdog not served first");

  property p_xack_one;
    @(posedge clk_i) disable iff (rst_i)
      $onehot0(ext_irq_ack_out_o);
  endproperty
  a_xack_one: assert property (p_xack_one) // [RL3]
    else $error("more than one external ack");

  property p_ack_clear;
    @(posedge clk_i) disable iff (rst_i)
      irq_ack_i && req_q && !set_v[idx_q] |=> !pend_q[$past(idx_q)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) // [RL7]
    else $error("pending not cleared on ack");

  property p_sync_first;
    @(posedge clk_i) disable iff (rst_i)
      sync_trap_i && !(irq_ack_i && req_q) |=> !irq_req_o;
  endproperty
  a_sync_first: assert property (p_sync_first) // [RL16]
    else $error("interrupt beside synchronous trap");

  property p_pp_pulse;
    @(posedge clk_i) disable iff (rst_i)
      pp_evt |=> parport_irq_pulse_o [*2];
  endproperty
  a_pp_pulse: assert property (p_pp_pulse) // [RL18]
    else $error("parallel-port pulse too short");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      |ext_lvl |=> !power_down_o;
  endproperty
  a_wake: assert property (p_wake) // [RL15]
    else $error("no wake on external input");

  property p_err_out;
    @(posedge clk_i) disable iff (rst_i)
      hw_err |=> error_out_o;
  endproperty
  a_err_out: assert property (p_err_out) // [RL17]
    else $error("error output missing");

endmodule : atic_ctrl

// *** atic_pkg.sv ***
// atic_pkg: constants for the asynchronous trap interrupt controller
// assumes: single 25 MHz system clock, synchronous reset
package atic_pkg;

  localparam int NUM_SRC   = 15;
  localparam int NUM_EXT   = 5;
  localparam int PP_WIDTH  = 8;

  // source index = priority level minus 13
  localparam int LEVEL_BASE  = 13;
  localparam int SRC_WDOG    = 0;
  localparam int SRC_EXT4    = 1;
  localparam int SRC_RTT     = 2;
  localparam int SRC_GPT     = 3;
  localparam int SRC_EXT3    = 4;
  localparam int SRC_EXT2    = 5;
  localparam int SRC_DMA_TO  = 6;
  localparam int SRC_DMA_ERR = 7;
  localparam int SRC_UERR    = 8;
  localparam int SRC_ECC     = 9;
  localparam int SRC_UARTB   = 10;
  localparam int SRC_UARTA   = 11;
  localparam int SRC_EXT1    = 12;
  localparam int SRC_EXT0    = 13;
  localparam int SRC_HWERR   = 14;

  // trap type of lowest level, each higher level one less
  localparam logic [7:0] TT_TOP     = 8'h1F;
  localparam logic [7:0] TT_BOTTOM  = 8'h11;
  localparam logic [7:0] TT_DATA_EX = 8'h09;
  localparam logic [7:0] TT_TAG_OV  = 8'h0A;
  localparam logic [7:0] TT_TRAP_LO = 8'h80;

  // parallel-port pulse width in system clocks
  localparam int PP_PULSE_CYC = 2;

  // watchdog reset timeout after the time-out request, in clocks
  localparam int WD_RST_CYC_DEF = 1024;

  localparam logic [NUM_SRC-1:0] PEND_RST = '0;

endpackage : atic_pkg

// *** tb.sv ***
// tb: self-checking bench for atic_ctrl with a core model
// assumes: atic_pkg, atic_ctrl and atic_core_model compiled first
`timescale 1ns/100ps
module tb;
  import atic_pkg::*;
  localparam int WD = 8;
  localparam int SL [8] = '{SRC_RTT, SRC_GPT, SRC_DMA_TO, SRC_DMA_ERR,
                            SRC_UERR, SRC_ECC, SRC_UARTB, SRC_UARTA};
  localparam int EXL [5] = '{SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT3,
                             SRC_EXT4};
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [NUM_SRC-1:0] ev    = '0;
  logic [NUM_SRC-1:0] imask = '1;
  logic [NUM_EXT-1:0] ext   = '0;
  logic [NUM_EXT-1:0] ext_hi = 5'h1F;
  logic [NUM_EXT-1:0] ext_edge = 5'h1F;
  logic [NUM_EXT-1:0] ext_ack;
  logic               ewd = 1'b0, wexp = 1'b0, rld = 1'b0;
  logic [3:0]         herr = 4'h0;
  logic               internal_wdog_enable_pin = 1'b1;
  logic               pdreq = 1'b0, strap = 1'b0, ack_en = 1'b1;
  logic [2:0]         emask = 3'h4;
  logic [7:0]         pp = 8'h00, ppsel = 8'h01;
  logic [3:0]         dly = 4'h0;
  logic               req, pdo, erro, wrst, ppul, ack, taken;
  logic [7:0]         typ, ttype;
  logic [4:0]         est;
  int                 error_cnt = 0;
  int                 samples_checked = 0;

  initial forever #20 clk_i = ~clk_i;

  atic_ctrl #(.WD_RST_CYC(WD)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ext_irq_in_i(ext),
    .ext_watchdog_irq_in_i(ewd), .internal_wdog_enable_pin_i(internal_wdog_enable_pin),
    .wdog_expired_i(wexp), .wdog_reload_i(rld),
    .realtime_timer_done_i(ev[SRC_RTT]), .general_timer_done_i(ev[SRC_GPT]),
    .dma_timeout_i(ev[SRC_DMA_TO]), .dma_access_err_i(ev[SRC_DMA_ERR]),
    .uart_err_i(ev[SRC_UERR]), .ecc_corrected_i(ev[SRC_ECC]),
    .uart_b_event_i(ev[SRC_UARTB]), .uart_a_event_i(ev[SRC_UARTA]),
    .iu_hw_err_i(herr[0]), .iu_err_mode_i(herr[1]),
    .sys_hw_err_i(herr[2]),
    .fpu_err_i(herr[3]), .err_mask_i(emask), .irq_mask_i(imask),
    .ext_active_high_i(ext_hi), .ext_edge_i(ext_edge),
    .power_down_req_i(pdreq), .parallel_port_i(pp),
    .parallel_port_sel_i(ppsel), .sync_trap_i(strap), .irq_ack_i(ack),
    .irq_req_o(req), .irq_type_o(typ), .ext_irq_ack_out_o(ext_ack),
    .power_down_o(pdo), .error_out_o(erro), .err_status_o(est),
    .wdog_reset_o(wrst), .parport_irq_pulse_o(ppul));

  atic_core_model i_core (
    .clk_i(clk_i), .rst_i(rst_i), .irq_req_i(req), .irq_type_i(typ),
    .ack_en_i(ack_en), .ack_dly_i(dly), .irq_ack_o(ack),
    .taken_o(taken), .taken_type_o(ttype));

  // ==========================================
  // shared tasks
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic final_report();
    $display("counts: errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic pulse(input int s);
    ev[s] = 1'b1;
    cyc(1);
    ev[s] = 1'b0;
  endtask : pulse
  task automatic take(input logic [7:0] exp, input string m);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
      if (n > 60) begin
        chk(1'b0, {m, " timeout"});
        final_report();
      end
    end while (taken !== 1'b1);
    chk(ttype === exp, m);
    chk(req === 1'b0, {m, " req kept"});
  endtask : take
  task automatic wait_sig(input logic pick_pp, input logic v,
                          input int lim, output int n);
    n = 0;
    while ((pick_pp ? ppul : wrst) !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk(1'b0, "wait timeout");
        final_report();
      end
    end
  endtask : wait_sig

  // ==========================================
  // scenarios
  task automatic t_src();
    foreach (SL[i]) begin
      pulse(SL[i]);
      take(TT_TOP - 8'(SL[i]), "source type");
    end
    dly = 4'h3;
    ev[SRC_RTT] = 1'b1;
    ev[SRC_GPT] = 1'b1;
    cyc(1);
    ev = '0;
    take(8'h1D, "rtt first");
    take(8'h1C, "gpt next");
    dly = 4'h0;
    $display("t_src done");
  endtask : t_src
  task automatic t_mask();
    imask[SRC_UARTA] = 1'b0;
    pulse(SRC_UARTA);
    cyc(8);
    chk(req === 1'b0, "masked source shown");
    imask = '1;
    take(8'h14, "unmasked pending");
    imask = '0;
    ewd = 1'b1;
    cyc(3);
    ewd = 1'b0;
    take(TT_TOP, "watchdog pin");
    imask = '1;
    strap = 1'b1;
    pulse(SRC_UARTB);
    cyc(6);
    chk(req === 1'b0, "sync trap");
    strap = 1'b0;
    take(8'h15, "after sync trap");
    $display("t_mask done");
  endtask : t_mask
  task automatic t_ext();
    foreach (EXL[i]) begin
      ext[i] = 1'b1;
      take(TT_TOP - 8'(EXL[i]), "ext type");
      chk(ext_ack === 5'(1 << i), "ext ack");
      ext[i] = 1'b0;
    end
    ext_hi[0] = 1'b0;
    ext[0] = 1'b1;
    cyc(3);
    ext_edge[0] = 1'b0;
    cyc(6);
    chk(req === 1'b0, "low line idle");
    ack_en = 1'b0;
    pdreq = 1'b1;
    cyc(1);
    pdreq = 1'b0;
    cyc(2);
    chk(pdo === 1'b1, "power-down");
    ext[0] = 1'b0;
    cyc(5);
    chk(pdo === 1'b0, "wake");
    ext[0] = 1'b1;
    cyc(3);
    ack_en = 1'b1;
    take(8'h12, "level low line");
    cyc(6);
    chk(req === 1'b0, "level released");
    $display("t_ext done");
  endtask : t_ext
  task automatic t_err();
    int n;
    herr = 4'h1;
    cyc(1);
    herr = 4'h0;
    chk(erro === 1'b1, "error out");
    take(TT_BOTTOM, "hw error");
    chk(est[1] === 1'b1, "error latched");
    herr = 4'hE;
    cyc(1);
    herr = 4'h0;
    chk(erro === 1'b0, "masked error out");
    cyc(1);
    chk(est[4:2] === 3'h7 && req === 1'b0, "masked latch");
    ack_en = 1'b0;
    wexp = 1'b1;
    cyc(1);
    wexp = 1'b0;
    cyc(2);
    rld = 1'b1;
    cyc(1);
    rld = 1'b0;
    cyc(WD + 4);
    chk(est[0] === 1'b0, "reload stops timeout");
    wexp = 1'b1;
    cyc(1);
    wexp = 1'b0;
    wait_sig(1'b0, 1'b1, WD + 10, n);
    chk(wrst === 1'b1 && n == WD, "wdog reset");
    cyc(1);
    chk(est[0] === 1'b1, "wdog status");
    ack_en = 1'b1;
    take(TT_TOP, "wdog request");
    $display("t_err done");
  endtask : t_err
  task automatic t_pp();
    int n;
    repeat (2) begin
      pp[0] = ~pp[0];
      wait_sig(1'b1, 1'b1, 10, n);
      wait_sig(1'b1, 1'b0, 10, n);
      chk(n == PP_PULSE_CYC, "pulse width");
    end
    pp[1] = 1'b1;
    cyc(8);
    chk(ppul === 1'b0, "unselected pin");
    $display("t_pp done");
  endtask : t_pp

  initial begin
    cyc(6);
    rst_i = 1'b0;
    chk(typ === TT_TOP && req === 1'b0 && est === 5'h00, "reset");
    cyc(3);
    t_src();
    t_mask();
    t_ext();
    t_err();
    t_pp();
    final_report();
  end
endmodule : tb
